// ===== src/atp_pkg.sv
// Package: constants and types for the ATA task file port
package atp_pkg;

  // ==========================================================
  // Register selects (CS1-, CS0-, DA) and duplicate offsets
  // ==========================================================
  localparam logic [2:0] DA_DATA = 3'h0;
  localparam logic [2:0] DA_ERR_FEAT = 3'h1;
  localparam logic [2:0] DA_SEC_CNT = 3'h2;
  localparam logic [2:0] DA_SEC_NUM = 3'h3;
  localparam logic [2:0] DA_CYL_LO = 3'h4;
  localparam logic [2:0] DA_CYL_HI = 3'h5;
  localparam logic [2:0] DA_DEV_HEAD = 3'h6;
  localparam logic [2:0] DA_STAT_CMD = 3'h7;
  localparam logic [2:0] DA_ALT_CTRL = 3'h6;
  localparam logic [2:0] DA_OBSOLETE = 3'h7;
  localparam logic [3:0] OFS_DUP_DATA_EVEN = 4'h8;
  localparam logic [3:0] OFS_DUP_DATA_ODD = 4'h9;
  localparam logic [3:0] OFS_DUP_ERR_FEAT = 4'hd;

  // ==========================================================
  // Reset values of the task file
  // ==========================================================
  localparam logic [7:0] RST_SEC_CNT = 8'h01;
  localparam logic [7:0] RST_SEC_NUM = 8'h01;
  localparam logic [7:0] RST_CYL_LO = 8'h00;
  localparam logic [7:0] RST_CYL_HI = 8'h00;
  localparam logic [7:0] RST_DEV_HEAD = 8'ha0;
  localparam logic [7:0] RST_DEV_CTRL = 8'h00;
  localparam logic [7:0] SEC_NUM_MIN = 8'h01;
  localparam logic [7:0] SEC_NUM_MAX = 8'h20;

  // Status and control bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int DC_SRST = 2;
  localparam int DC_NIEN = 1;
  localparam int DH_LBA = 6;
  localparam logic [7:0] ERR_ABRT = 8'h04;
  localparam logic [7:0] DIAG_OK = 8'h01;

  // ==========================================================
  // PIO modes and timing
  // ==========================================================
  localparam logic [2:0] PIO_MODE_RESET = 3'h0;
  localparam logic [2:0] PIO_MODE_IORDY_MIN = 3'h3;
  localparam logic [7:0] FEAT_SET_XFER = 8'h03;
  localparam logic [4:0] XFER_PIO_FLOW = 5'h01;
  localparam int CLK_MHZ = 200;
  localparam int T_RD_NS = 5;
  localparam int T_RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
  localparam int T_BUSY_NS = 100;
  localparam int T_BUSY_CYC = (T_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int WORDS_PER_SECTOR = 256;

  // ==========================================================
  // Command classes
  // ==========================================================
  typedef enum logic [4:0] {
    ATP_CMD_NONE, ATP_CMD_CHK_PWR, ATP_CMD_DIAG, ATP_CMD_ERASE, ATP_CMD_FORMAT,
    ATP_CMD_IDENT, ATP_CMD_READ, ATP_CMD_READ_MULT, ATP_CMD_VERIFY, ATP_CMD_READ_LONG,
    ATP_CMD_WRITE, ATP_CMD_WRITE_MULT, ATP_CMD_WRITE_NE, ATP_CMD_WRITE_MULT_NE,
    ATP_CMD_WRITE_VFY, ATP_CMD_WRITE_LONG, ATP_CMD_IDLE, ATP_CMD_IDLE_IMM,
    ATP_CMD_STANDBY, ATP_CMD_STANDBY_IMM, ATP_CMD_SLEEP, ATP_CMD_INIT_PARAM,
    ATP_CMD_BUF_READ, ATP_CMD_BUF_WRITE, ATP_CMD_RECAL, ATP_CMD_SEEK,
    ATP_CMD_SET_FEAT, ATP_CMD_SET_MULT, ATP_CMD_REQ_SENSE, ATP_CMD_TRANSLATE,
    ATP_CMD_WEAR
  } atp_cmd_type;

  typedef enum logic [1:0] {
    ATP_DIR_NONE, ATP_DIR_IN, ATP_DIR_OUT
  } atp_dir_type;

endpackage : atp_pkg

// ===== src/atp_cmd_decode.sv
// Command opcode decoder for the ATA task file port
`timescale 1ns/1ps
`default_nettype none

module atp_cmd_decode (
  input wire logic [7:0] code_i, // Command register value
  output atp_pkg::atp_cmd_type cmd_o, // Decoded command class
  output atp_pkg::atp_dir_type dir_o // Data phase direction
);

  always_comb begin
    cmd_o = atp_pkg::ATP_CMD_NONE;
    case (code_i)
      8'he5, 8'h98: cmd_o = atp_pkg::ATP_CMD_CHK_PWR;
      8'h90: cmd_o = atp_pkg::ATP_CMD_DIAG;
      8'hc0: cmd_o = atp_pkg::ATP_CMD_ERASE;
      8'h50: cmd_o = atp_pkg::ATP_CMD_FORMAT;
      8'hec: cmd_o = atp_pkg::ATP_CMD_IDENT;
      8'h20, 8'h21: cmd_o = atp_pkg::ATP_CMD_READ;
      8'hc4: cmd_o = atp_pkg::ATP_CMD_READ_MULT;
      8'h40, 8'h41: cmd_o = atp_pkg::ATP_CMD_VERIFY;
      8'h22, 8'h23: cmd_o = atp_pkg::ATP_CMD_READ_LONG;
      8'h30, 8'h31: cmd_o = atp_pkg::ATP_CMD_WRITE;
      8'hc5: cmd_o = atp_pkg::ATP_CMD_WRITE_MULT;
      8'h38: cmd_o = atp_pkg::ATP_CMD_WRITE_NE;
      8'hcd: cmd_o = atp_pkg::ATP_CMD_WRITE_MULT_NE;
      8'h3c: cmd_o = atp_pkg::ATP_CMD_WRITE_VFY;
      8'h32, 8'h33: cmd_o = atp_pkg::ATP_CMD_WRITE_LONG;
      8'he3, 8'h97: cmd_o = atp_pkg::ATP_CMD_IDLE;
      8'he1, 8'h95: cmd_o = atp_pkg::ATP_CMD_IDLE_IMM;
      8'he2, 8'h96: cmd_o = atp_pkg::ATP_CMD_STANDBY;
      8'he0, 8'h94: cmd_o = atp_pkg::ATP_CMD_STANDBY_IMM;
      8'he6, 8'h99: cmd_o = atp_pkg::ATP_CMD_SLEEP;
      8'h91: cmd_o = atp_pkg::ATP_CMD_INIT_PARAM;
      8'he4: cmd_o = atp_pkg::ATP_CMD_BUF_READ;
      8'he8: cmd_o = atp_pkg::ATP_CMD_BUF_WRITE;
      8'hef: cmd_o = atp_pkg::ATP_CMD_SET_FEAT;
      8'hc6: cmd_o = atp_pkg::ATP_CMD_SET_MULT;
      8'h03: cmd_o = atp_pkg::ATP_CMD_REQ_SENSE;
      8'h87: cmd_o = atp_pkg::ATP_CMD_TRANSLATE;
      8'hf5: cmd_o = atp_pkg::ATP_CMD_WEAR;
      default: begin
        if (code_i[7:4] == 4'h1) begin
          cmd_o = atp_pkg::ATP_CMD_RECAL;
        end else if (code_i[7:4] == 4'h7) begin
          cmd_o = atp_pkg::ATP_CMD_SEEK;
        end
      end
    endcase
  end

  always_comb begin
    case (cmd_o)
      atp_pkg::ATP_CMD_IDENT, atp_pkg::ATP_CMD_READ, atp_pkg::ATP_CMD_READ_MULT,
      atp_pkg::ATP_CMD_READ_LONG, atp_pkg::ATP_CMD_BUF_READ: dir_o = atp_pkg::ATP_DIR_IN;
      atp_pkg::ATP_CMD_FORMAT, atp_pkg::ATP_CMD_WRITE, atp_pkg::ATP_CMD_WRITE_MULT,
      atp_pkg::ATP_CMD_WRITE_NE, atp_pkg::ATP_CMD_WRITE_MULT_NE, atp_pkg::ATP_CMD_WRITE_VFY,
      atp_pkg::ATP_CMD_WRITE_LONG, atp_pkg::ATP_CMD_BUF_WRITE: dir_o = atp_pkg::ATP_DIR_OUT;
      default: dir_o = atp_pkg::ATP_DIR_NONE;
    endcase
  end

endmodule : atp_cmd_decode
`default_nettype wire

// ===== src/atp_task_file.sv
// Task file register port of the ATA storage device (PIO side)
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Both chip selects negated: no drive, writes ignored
// - CS0 block decodes DA to task file registers
// - LBA bits spread over number, cylinders, head
// - Obsolete control address never drives bit seven
// - Word access hides error/feature; copies used instead
// - Duplicate data: even byte 08h, odd 09h
// - Error/feature copy at 0Dh on low byte
// - Reset and diagnostic load fixed task file values
// - Power-up PIO mode is zero
// - Host respects minimum cycle of modes three up
// - Ready flow control used in modes three and up
// - Long transfers carry vendor byte in low bits
// - Ready low at host sample point inserts wait
// - Read data valid before ready reasserts
// - E5H and 98H check power mode
// - 90H runs diagnostics then reinitialises task file
// - C0H erases addressed sectors
// - 50H accepts one sector, stores nothing
// - ECH returns parameter block through data
// - Read command codes decoded
// - Write command codes decoded
// - Sector count any value; number 01h to 20h
module atp_task_file (
  input wire logic clock_i, // 200 MHz clock
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic cs0_n_i, // Command block select, pin
  input wire logic cs1_n_i, // Control block select, pin
  input wire logic [2:0] da_i, // Device address, pin
  input wire logic dior_n_i, // Read strobe, pin
  input wire logic diow_n_i, // Write strobe, pin
  input wire logic [15:0] dd_i, // Data bus in, pin
  output logic [15:0] dd_o, // Data bus out
  output logic [15:0] dd_oe_o, // Data bus enable per bit
  output logic iordy_o, // Ready line level
  output logic iordy_oe_o, // Ready line enable
  input wire logic [3:0] mem_ofs_i, // Offset in contiguous/memory mode
  input wire logic mem_sel_i, // Offset addressing in use, pin
  input wire logic mem_word_i, // Word access in offset mode, pin
  output logic [27:0] lba_o, // Logical block address
  output logic [7:0] sec_cnt_o, // Sector count
  output logic [2:0] pio_mode_o, // Current PIO mode
  output logic cmd_go_o, // Command accepted pulse
  output logic [7:0] cmd_code_o, // Command code
  output logic [1:0] power_state_o, // 0 active, 1 idle, 2 standby, 3 sleep
  input wire logic [15:0] src_word_i, // Word from device buffer
  input wire logic src_ready_i, // Buffer word available
  output logic src_take_o, // Buffer word consumed
  output logic [15:0] sink_word_o, // Word to device buffer
  output logic sink_valid_o, // Sink word strobe
  output logic sink_discard_o, // Sink data must not be stored
  input wire logic op_done_i // Device finished command or block
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  localparam int SW = 29;
  logic [SW-1:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [SW-1:0] pin_raw;
  assign pin_raw = {cs0_n_i, cs1_n_i, da_i, dior_n_i, diow_n_i, dd_i,
                    mem_ofs_i, mem_sel_i, mem_word_i};
  always_ff @(posedge clock_i) begin
    pin_meta_reg <= pin_raw;
    pin_sync_reg <= pin_meta_reg;
    pin_prev_reg <= pin_sync_reg;
  end
  logic cs0_n, cs1_n, rd_n, wr_n, msel, mword;
  logic [2:0] da;
  logic [15:0] dd;
  logic [3:0] mofs;
  assign {cs0_n, cs1_n, da, rd_n, wr_n, dd, mofs, msel, mword} = pin_sync_reg;
  logic rd_fall, wr_rise, rd_rise;
  // Bit 23 of the vector is the read strobe, bit 22 the write strobe
  assign rd_fall = pin_prev_reg[23] & ~rd_n;
  assign rd_rise = ~pin_prev_reg[23] & rd_n;
  assign wr_rise = ~pin_prev_reg[22] & wr_n; // Data latched on DIOW- rising edge

  // ==========================================================
  // Address decode
  // ==========================================================
  typedef enum logic [3:0] {
    ATP_R_NONE, ATP_R_DATA, ATP_R_ERRF, ATP_R_SCNT, ATP_R_SNUM, ATP_R_CLO,
    ATP_R_CHI, ATP_R_DH, ATP_R_STCMD, ATP_R_ALT, ATP_R_OBS
  } atp_reg_type;

  function automatic atp_reg_type decode(input logic c0n, input logic c1n,
                                         input logic [2:0] a, input logic ms,
                                         input logic [3:0] ofs);
    logic cmd_blk;
    logic [2:0] ra;
    decode = ATP_R_NONE;
    // Offsets 0h to 7h mirror the command block, so both modes share one decode
    cmd_blk = ms ? (ofs[3] == 1'b0) : (!c0n && c1n);
    ra = ms ? ofs[2:0] : a;
    if (c0n && c1n) begin
      decode = ATP_R_NONE;
    end else if (ms && (ofs == atp_pkg::OFS_DUP_DATA_EVEN ||
                        ofs == atp_pkg::OFS_DUP_DATA_ODD)) begin
      decode = ATP_R_DATA;
    end else if (ms && ofs == atp_pkg::OFS_DUP_ERR_FEAT) begin
      decode = ATP_R_ERRF;
    end else if (ms && ofs[3:2] == 2'b11 && ofs[1:0] == 2'b10) begin
      decode = ATP_R_ALT;
    end else if (cmd_blk) begin
      case (ra)
        atp_pkg::DA_DATA: decode = ATP_R_DATA;
        atp_pkg::DA_ERR_FEAT: decode = ATP_R_ERRF;
        atp_pkg::DA_SEC_CNT: decode = ATP_R_SCNT;
        atp_pkg::DA_SEC_NUM: decode = ATP_R_SNUM;
        atp_pkg::DA_CYL_LO: decode = ATP_R_CLO;
        atp_pkg::DA_CYL_HI: decode = ATP_R_CHI;
        atp_pkg::DA_DEV_HEAD: decode = ATP_R_DH;
        default: decode = ATP_R_STCMD;
      endcase
    end else if (!ms && c0n && !c1n) begin
      if (a == atp_pkg::DA_ALT_CTRL) begin
        decode = ATP_R_ALT;
      end else if (a == atp_pkg::DA_OBSOLETE) begin
        decode = ATP_R_OBS;
      end
    end
  endfunction : decode

  atp_reg_type sel;
  assign sel = decode(cs0_n, cs1_n, da, msel, mofs);
  // In offset mode a word access at offset 1 would collide with data; the copies serve.
  logic word_xfer;
  assign word_xfer = msel ? mword : (sel == ATP_R_DATA);

  // ==========================================================
  // Task file and command state
  // ==========================================================
  typedef enum logic [1:0] {ATP_S_IDLE, ATP_S_BUSY, ATP_S_XFER} atp_state_type;
  atp_state_type st_reg, st_next;
  logic [7:0] feat_reg, feat_next, err_reg, err_next, scnt_reg, scnt_next;
  logic [7:0] snum_reg, snum_next, clo_reg, clo_next, chi_reg, chi_next;
  logic [7:0] dh_reg, dh_next, dctl_reg, dctl_next, cmd_reg, cmd_next;
  logic [2:0] pio_reg, pio_next;
  logic [1:0] pwr_reg, pwr_next;
  logic [8:0] words_reg, words_next;
  logic [7:0] blocks_reg, blocks_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [4:0] hold_reg, hold_next;
  // Read wait kept apart from the busy countdown so status polling cannot cut busy short
  logic [4:0] rdw_reg, rdw_next;
  logic go_reg, go_next, err_st_reg, err_st_next, seen_rst_reg;
  atp_pkg::atp_cmd_type cmd_cls;
  atp_pkg::atp_dir_type cmd_dir;

  atp_cmd_decode u_dec (
    .code_i(dd[7:0]),
    .cmd_o(cmd_cls),
    .dir_o(cmd_dir)
  );
  atp_pkg::atp_cmd_type cur_cls;
  atp_pkg::atp_dir_type cur_dir;
  atp_cmd_decode u_cur (
    .code_i(cmd_reg),
    .cmd_o(cur_cls),
    .dir_o(cur_dir)
  );

  logic [7:0] status;
  assign status = {st_reg == ATP_S_BUSY, st_reg != ATP_S_BUSY, 2'b00,
                   st_reg == ATP_S_XFER, 2'b00, err_st_reg};
  logic srst_bit;
  assign srst_bit = dctl_reg[atp_pkg::DC_SRST];
  logic data_rd, data_wr;
  assign data_rd = rd_rise && sel == ATP_R_DATA && st_reg == ATP_S_XFER && cur_dir == atp_pkg::ATP_DIR_IN;
  assign data_wr = wr_rise && sel == ATP_R_DATA && st_reg == ATP_S_XFER && cur_dir == atp_pkg::ATP_DIR_OUT;
  logic long_cmd;
  assign long_cmd = cur_cls == atp_pkg::ATP_CMD_READ_LONG || cur_cls == atp_pkg::ATP_CMD_WRITE_LONG;

  always_comb begin
    st_next = st_reg; feat_next = feat_reg; err_next = err_reg; scnt_next = scnt_reg;
    snum_next = snum_reg; clo_next = clo_reg; chi_next = chi_reg; dh_next = dh_reg;
    dctl_next = dctl_reg; cmd_next = cmd_reg; pio_next = pio_reg; pwr_next = pwr_reg;
    words_next = words_reg; blocks_next = blocks_reg; go_next = 1'b0;
    err_st_next = err_st_reg; rdata_next = rdata_reg;
    hold_next = (hold_reg != 5'h0) ? hold_reg - 5'h1 : 5'h0;
    rdw_next = (rdw_reg != 5'h0) ? rdw_reg - 5'h1 : 5'h0;
    if (wr_rise && sel == ATP_R_ALT) begin
      dctl_next = dd[7:0];
    end
    if (wr_rise && st_reg == ATP_S_IDLE) begin
      case (sel)
        ATP_R_ERRF: feat_next = msel && mword ? dd[15:8] : dd[7:0];
        ATP_R_SCNT: scnt_next = dd[7:0];
        ATP_R_SNUM: snum_next = dd[7:0];
        ATP_R_CLO: clo_next = dd[7:0];
        ATP_R_CHI: chi_next = dd[7:0];
        ATP_R_DH: dh_next = dd[7:0];
        ATP_R_STCMD: begin
          cmd_next = dd[7:0];
          go_next = 1'b1;
          err_st_next = 1'b0;
          err_next = 8'h00;
          st_next = ATP_S_BUSY;
          hold_next = 5'(atp_pkg::T_BUSY_CYC);
          // Out of range sector number on a CHS transfer is aborted
          if (cmd_cls == atp_pkg::ATP_CMD_NONE ||
              (!dh_reg[atp_pkg::DH_LBA] && cmd_dir != atp_pkg::ATP_DIR_NONE &&
               cmd_cls != atp_pkg::ATP_CMD_IDENT && cmd_cls != atp_pkg::ATP_CMD_BUF_READ &&
               cmd_cls != atp_pkg::ATP_CMD_BUF_WRITE &&
               (snum_reg < atp_pkg::SEC_NUM_MIN || snum_reg > atp_pkg::SEC_NUM_MAX))) begin
            go_next = 1'b0;
            err_st_next = 1'b1;
            err_next = atp_pkg::ERR_ABRT;
            st_next = ATP_S_IDLE;
          end
          case (cmd_cls)
            atp_pkg::ATP_CMD_IDLE, atp_pkg::ATP_CMD_IDLE_IMM: pwr_next = 2'd1;
            atp_pkg::ATP_CMD_STANDBY, atp_pkg::ATP_CMD_STANDBY_IMM: pwr_next = 2'd2;
            atp_pkg::ATP_CMD_SLEEP: pwr_next = 2'd3;
            atp_pkg::ATP_CMD_CHK_PWR: scnt_next = (pwr_reg == 2'd2) ? 8'h00 : 8'hff;
            atp_pkg::ATP_CMD_SET_FEAT: begin
              if (feat_reg == atp_pkg::FEAT_SET_XFER && scnt_reg[7:3] == atp_pkg::XFER_PIO_FLOW) begin
                pio_next = scnt_reg[2:0];
              end
            end
            default: pwr_next = 2'd0;
          endcase
        end
        default: ;
      endcase
    end
    case (st_reg)
      ATP_S_BUSY: begin
        if (hold_reg == 5'h0 && op_done_i) begin
          words_next = 9'h0;
          blocks_next = scnt_reg - 8'h01;
          if (cur_cls == atp_pkg::ATP_CMD_DIAG) begin
            scnt_next = atp_pkg::RST_SEC_CNT; snum_next = atp_pkg::RST_SEC_NUM;
            clo_next = atp_pkg::RST_CYL_LO; chi_next = atp_pkg::RST_CYL_HI;
            dh_next = atp_pkg::RST_DEV_HEAD; err_next = atp_pkg::DIAG_OK;
            st_next = ATP_S_IDLE;
          end else if (cur_dir != atp_pkg::ATP_DIR_NONE) begin
            st_next = ATP_S_XFER;
          end else begin
            st_next = ATP_S_IDLE;
          end
        end
      end
      ATP_S_XFER: begin
        if (data_rd || data_wr) begin
          words_next = words_reg + 9'h1;
          if (words_reg == 9'(atp_pkg::WORDS_PER_SECTOR - 1)) begin
            st_next = (blocks_reg == 8'h00 || cur_cls == atp_pkg::ATP_CMD_FORMAT ||
                       cur_cls == atp_pkg::ATP_CMD_IDENT) ? ATP_S_IDLE : ATP_S_BUSY;
            blocks_next = blocks_reg - 8'h01;
            hold_next = 5'(atp_pkg::T_BUSY_CYC);
          end
        end
      end
      default: ;
    endcase
    // Capture read data while ready is held low, giving lead time before release
    if (rd_fall) begin
      case (sel)
        ATP_R_DATA: rdata_next = (cur_dir == atp_pkg::ATP_DIR_IN && st_reg == ATP_S_XFER)
                                 ? (long_cmd ? {8'h00, src_word_i[7:0]} : src_word_i) : 16'h0;
        ATP_R_ERRF: rdata_next = (msel && mword) ? {err_reg, 8'h00} : {8'h00, err_reg};
        ATP_R_SCNT: rdata_next = {8'h00, scnt_reg};
        ATP_R_SNUM: rdata_next = {8'h00, snum_reg};
        ATP_R_CLO: rdata_next = {8'h00, clo_reg};
        ATP_R_CHI: rdata_next = {8'h00, chi_reg};
        ATP_R_DH: rdata_next = {8'h00, dh_reg};
        ATP_R_STCMD, ATP_R_ALT: rdata_next = {8'h00, status};
        default: rdata_next = 16'h0;
      endcase
      rdw_next = 5'(atp_pkg::T_RD_CYC);
    end
    if (srst_bit || !seen_rst_reg) begin
      st_next = ATP_S_IDLE; scnt_next = atp_pkg::RST_SEC_CNT; snum_next = atp_pkg::RST_SEC_NUM;
      clo_next = atp_pkg::RST_CYL_LO; chi_next = atp_pkg::RST_CYL_HI;
      dh_next = atp_pkg::RST_DEV_HEAD; err_next = atp_pkg::DIAG_OK; err_st_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_reg <= ATP_S_IDLE; feat_reg <= 8'h00; err_reg <= atp_pkg::DIAG_OK;
      scnt_reg <= atp_pkg::RST_SEC_CNT; snum_reg <= atp_pkg::RST_SEC_NUM;
      clo_reg <= atp_pkg::RST_CYL_LO; chi_reg <= atp_pkg::RST_CYL_HI;
      dh_reg <= atp_pkg::RST_DEV_HEAD; dctl_reg <= atp_pkg::RST_DEV_CTRL;
      cmd_reg <= 8'h00; pio_reg <= atp_pkg::PIO_MODE_RESET; pwr_reg <= 2'd0;
      words_reg <= 9'h0; blocks_reg <= 8'h00; go_reg <= 1'b0; err_st_reg <= 1'b0;
      rdata_reg <= 16'h0; hold_reg <= 5'h0; seen_rst_reg <= 1'b0;
      rdw_reg <= 5'h0;
    end else begin
      st_reg <= st_next; feat_reg <= feat_next; err_reg <= err_next;
      scnt_reg <= scnt_next; snum_reg <= snum_next; clo_reg <= clo_next;
      chi_reg <= chi_next; dh_reg <= dh_next; dctl_reg <= dctl_next;
      cmd_reg <= cmd_next; pio_reg <= pio_next; pwr_reg <= pwr_next;
      words_reg <= words_next; blocks_reg <= blocks_next; go_reg <= go_next;
      err_st_reg <= err_st_next; rdata_reg <= rdata_next; hold_reg <= hold_next;
      rdw_reg <= rdw_next;
      seen_rst_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Pin drive and outputs
  // ==========================================================
  logic rd_active;
  assign rd_active = ~rd_n && sel != ATP_R_NONE;
  assign dd_o = rdata_reg;
  always_comb begin
    dd_oe_o = 16'h0000;
    if (rd_active) begin
      dd_oe_o = word_xfer ? 16'hffff : ((msel && mword) ? 16'hff00 : 16'h00ff);
      if (sel == ATP_R_OBS) begin
        dd_oe_o = 16'h007f;
      end
    end
  end
  // In PIO modes three and up ready drives low while the read data settles; it is released otherwise
  assign iordy_o = 1'b0;
  assign iordy_oe_o = rd_active && rdw_reg != 5'h0 &&
                      pio_reg >= atp_pkg::PIO_MODE_IORDY_MIN;
  assign lba_o = {dh_reg[3:0], chi_reg, clo_reg, snum_reg};
  assign sec_cnt_o = scnt_reg;
  assign pio_mode_o = pio_reg;
  assign cmd_go_o = go_reg;
  assign cmd_code_o = cmd_reg;
  assign power_state_o = pwr_reg;
  assign src_take_o = data_rd;
  assign sink_word_o = long_cmd ? {8'h00, dd[7:0]} : dd;
  assign sink_valid_o = data_wr;
  assign sink_discard_o = cur_cls == atp_pkg::ATP_CMD_FORMAT;

endmodule : atp_task_file
`default_nettype wire

// ===== sim/atp_chk.sv
// Assertion checker watching the task file port pins
`timescale 1ns/1ps
`default_nettype none
module atp_chk (
  input wire logic clock_i, // Clock
  input wire logic srst_i, // Reset
  input wire logic cs0_n_i, // Command select
  input wire logic cs1_n_i, // Control select
  input wire logic [2:0] da_i, // Device address
  input wire logic [15:0] dd_oe_o, // Bus enables
  input wire logic iordy_oe_o, // Ready held low
  input wire logic [2:0] pio_mode_o, // PIO mode
  input wire logic [27:0] lba_o, // Block address
  input wire logic [7:0] sec_cnt_o, // Sector count
  input wire logic cmd_go_o, // Command pulse
  input wire logic [7:0] cmd_code_o // Command code
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ==========================================================
  // Pin rules, four cycles allowed for the pin synchronisers
  no_drive_a: assert property ((cs0_n_i && cs1_n_i)[*4] |-> dd_oe_o == 16'h0)
    else $error("Bus driven with no chip select");
  obs_bit7_a: assert property ((cs0_n_i && !cs1_n_i && da_i == 3'h7)[*4] |-> !dd_oe_o[7])
    else $error("Bit seven driven on obsolete address");
  reset_file_a: assert property ($fell(srst_i) |-> sec_cnt_o == 8'h01 && lba_o == 28'h0000001)
    else $error("Task file wrong after reset");
  boot_mode_a: assert property ($fell(srst_i) |-> pio_mode_o <= 3'h2)
    else $error("Fast PIO mode after reset");
  wait_mode_a: assert property (iordy_oe_o |-> pio_mode_o >= 3'h3)
    else $error("Wait inserted in slow mode");
  wait_len_a: assert property ($rose(iordy_oe_o) |-> ##[1:4] !iordy_oe_o)
    else $error("Ready held low too long");
  go_pulse_a: assert property (cmd_go_o |=> !cmd_go_o)
    else $error("Command pulse longer than one cycle");
  diag_init_a: assert property (cmd_go_o && cmd_code_o == 8'h90 |-> ##[1:300] lba_o == 28'h0000001)
    else $error("Diagnostic left task file unchanged");
endmodule : atp_chk
`default_nettype wire

// ===== sim/atp_host.sv
// Host adapter model driving PIO register cycles
`timescale 1ns/1ps
`default_nettype none
module atp_host (
  input wire logic clock_i, // Clock
  output logic cs0_n_o, // Command block select
  output logic cs1_n_o, // Control block select
  output logic [3:0] adr_o, // Device address and offset
  output logic msel_o, // Offset addressing
  output logic dior_n_o, // Read strobe
  output logic diow_n_o, // Write strobe
  output logic [15:0] dd_o, // Host side of data bus
  input wire logic [15:0] dd_i, // Device read data
  input wire logic iordy_oe_i // Device holds ready low
);
  logic [15:0] last = 16'h0;
  logic wen = 1'b0;
  int waits = 0;
  // Released bus must not show the stale value
  assign dd_o = wen ? last : ~last;
  initial {cs1_n_o, cs0_n_o, msel_o, adr_o, dior_n_o, diow_n_o} = 9'h183;
  // ==========================================================
  // One register cycle; a[4] selects offset addressing
  task automatic cyc(input logic [1:0] cs, input logic [4:0] a, input logic w,
      input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clock_i);
    {cs1_n_o, cs0_n_o, msel_o, adr_o} <= {~cs, a};
    {last, wen} <= {8'h00, d, w};
    repeat (2) @(posedge clock_i);
    {dior_n_o, diow_n_o} <= w ? 2'b10 : 2'b01;
    repeat (3) @(posedge clock_i);
    // Ready is looked at after the edge has settled, not in the edge's own time step
    #1;
    for (n = 0; n < 40 && iordy_oe_i; n++) begin
      waits++;
      @(posedge clock_i);
      #1;
    end
    repeat (4) @(posedge clock_i);
    q = dd_i[7:0];
    {dior_n_o, diow_n_o} <= 2'b11;
    repeat (5) @(posedge clock_i);
    {cs1_n_o, cs0_n_o, wen} <= 3'b110;
  endtask : cyc
endmodule : atp_host
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking testbench of the task file port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic cs0_n, cs1_n, msel, dior_n, diow_n, iordy_oe, cmd_go;
  logic [3:0] adr;
  logic [15:0] bus, rdat;
  logic [27:0] lba;
  logic [7:0] cmd_code, last_cmd, q;
  logic [2:0] pio;
  logic [7:0] pc [2] = '{8'he5, 8'h98};
  int n_fail = 0;
  int comparisons = 0;
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) if (cmd_go) last_cmd <= cmd_code;
  atp_host u_host (.clock_i, .cs0_n_o(cs0_n), .cs1_n_o(cs1_n), .adr_o(adr), .msel_o(msel),
    .dior_n_o(dior_n), .diow_n_o(diow_n), .dd_o(bus), .dd_i(rdat), .iordy_oe_i(iordy_oe));
  atp_task_file u_dut (.clock_i, .srst_i, .cs0_n_i(cs0_n), .cs1_n_i(cs1_n), .da_i(adr[2:0]),
    .dior_n_i(dior_n), .diow_n_i(diow_n), .dd_i(bus), .dd_o(rdat), .dd_oe_o(), .iordy_o(),
    .iordy_oe_o(iordy_oe), .mem_ofs_i(adr), .mem_sel_i(msel), .mem_word_i(1'b0), .lba_o(lba),
    .sec_cnt_o(), .pio_mode_o(pio), .cmd_go_o(cmd_go), .cmd_code_o(cmd_code), .power_state_o(),
    .src_word_i(16'h0000), .src_ready_i(1'b1), .src_take_o(), .sink_word_o(), .sink_valid_o(),
    .sink_discard_o(), .op_done_i(1'b1));
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [1:0] cs, input logic [4:0] a, input logic [7:0] e, string nm);
    logic [7:0] g;
    u_host.cyc(cs, a, 1'b0, 8'h00, g);
    chk(nm, 28'(e), 28'(g));
  endtask : rd
  task automatic results;
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // ==========================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rd(2'b01, 5'h02, 8'h01, "sec_cnt");
    rd(2'b01, 5'h06, 8'ha0, "dev_head");
    u_host.cyc(2'b01, 5'h03, 1'b1, 8'h12, q);
    u_host.cyc(2'b01, 5'h04, 1'b1, 8'h34, q);
    u_host.cyc(2'b01, 5'h05, 1'b1, 8'h56, q);
    u_host.cyc(2'b01, 5'h06, 1'b1, 8'he7, q);
    chk("lba", 28'h7563412, lba);
    u_host.cyc(2'b00, 5'h04, 1'b1, 8'h99, q);
    rd(2'b01, 5'h04, 8'h34, "cyl_lo");
    rd(2'b10, 5'h07, 8'h00, "obsolete");
    u_host.cyc(2'b10, 5'h06, 1'b1, 8'h00, q);
    rd(2'b10, 5'h06, 8'h40, "alt_status");
    u_host.cyc(2'b01, 5'h07, 1'b1, 8'h90, q);
    repeat (100) @(posedge clock_i);
    chk("cmd", 28'h90, 28'(last_cmd));
    rd(2'b01, 5'h03, 8'h01, "sec_num");
    rd(2'b01, 5'h01, 8'h01, "error");
    rd(2'b01, 5'h1d, 8'h01, "error_copy");
    foreach (pc[i]) begin
      u_host.cyc(2'b01, 5'h02, 1'b1, 8'h5a, q);
      u_host.cyc(2'b01, 5'h07, 1'b1, pc[i], q);
      repeat (100) @(posedge clock_i);
      rd(2'b01, 5'h02, 8'hff, "power");
    end
    u_host.cyc(2'b01, 5'h01, 1'b1, 8'h03, q);
    u_host.cyc(2'b01, 5'h02, 1'b1, 8'h0b, q);
    u_host.cyc(2'b01, 5'h07, 1'b1, 8'hef, q);
    repeat (100) @(posedge clock_i);
    chk("pio", 28'h3, 28'(pio));
    rd(2'b01, 5'h04, 8'h00, "cyl_lo_wait");
    chk("waits", 28'h1, 28'(u_host.waits));
    results();
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule : testbench
bind atp_task_file atp_chk u_chk (.clock_i, .srst_i, .cs0_n_i, .cs1_n_i, .da_i, .dd_oe_o,
  .iordy_oe_o, .pio_mode_o, .lba_o, .sec_cnt_o, .cmd_go_o, .cmd_code_o);
`default_nettype wire
